// ---- shared/adc_mode_control_params.svh ----
// offsets, field codes, reset values and timing counts of the mode control block
`ifndef ADC_MODE_CONTROL_PARAMS_SVH
`define ADC_MODE_CONTROL_PARAMS_SVH

`define ADDR_MODE_CTL 8'h01
`define ADDR_IF_MODE 8'h02
`define ADDR_IRQ_STATUS 8'h10
`define ADDR_IRQ_MASK 8'h11
`define ADDR_STATE 8'h12

`define MODE_CTL_RESET 16'h8000
`define MODE_CTL_WMASK 16'ha77c
`define IF_MODE_RESET 16'h0000
`define IF_MODE_WMASK 16'h0400
`define IF_DELAY_ABSORB_BIT 10

`define OP_CONTINUOUS 3'h0
`define OP_SINGLE 3'h1
`define OP_STANDBY 3'h2
`define OP_POWER_DOWN 3'h3
`define OP_INT_OFFSET_CAL 3'h4
`define OP_UNDEFINED 3'h5
`define OP_SYS_OFFSET_CAL 3'h6
`define OP_SYS_GAIN_CAL 3'h7

`define CLK_INT_OSC 2'h0
`define CLK_INT_OSC_OUT 2'h1
`define CLK_EXT_CLOCK 2'h2
`define CLK_EXT_CRYSTAL 2'h3

`define IRQ_BITS 3
`define IRQ_RESULT 0
`define IRQ_CAL_DONE 1
`define IRQ_DELAY_DONE 2

`define CLK_PERIOD_NS 10
`define DLY_4US_NS 4000
`define DLY_16US_NS 16000
`define DLY_40US_NS 40000
`define DLY_100US_NS 100000
`define DLY_200US_NS 200000
`define DLY_500US_NS 500000
`define DLY_1MS_NS 1000000
`define NS_TO_CYC(ns) (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ---- shared/adc_mode_control_pkg.sv ----
// types shared by the mode control block
package adc_mode_control_pkg;

  typedef struct packed {
    logic ref_en;
    logic rsv14;
    logic settled_rate_only;
    logic [1:0] rsv12_11;
    logic [2:0] delay_sel;
    logic rsv7;
    logic [2:0] op_mode;
    logic [1:0] clock_source_select;
    logic [1:0] rsv1_0;
  } mode_ctl_t;

  typedef struct packed {
    logic osc_on;
    logic osc_to_crystal_pin_two;
    logic ext_clock_in;
    logic crystal_on;
  } clock_ctl_t;

  typedef enum logic [2:0] {
    st_idle,
    st_convert,
    st_delay,
    st_calib
  } seq_state_t;

endpackage

// ---- src/adc_mode_control.sv ----
// mode control register, conversion sequencer and interrupt logic
`timescale 1ns/100ps

`include "adc_mode_control_params.svh"

module adc_mode_control
  import adc_mode_control_pkg::*;
#(
  parameter int unsigned DELAY_100US_CYC = `NS_TO_CYC(`DLY_100US_NS),
  parameter int unsigned DELAY_200US_CYC = `NS_TO_CYC(`DLY_200US_NS),
  parameter int unsigned DELAY_500US_CYC = `NS_TO_CYC(`DLY_500US_NS),
  parameter int unsigned DELAY_1MS_CYC = `NS_TO_CYC(`DLY_1MS_NS)
) (
  input wire logic clock, // 100 MHz
  input wire logic reset_n, // async, active low
  input wire logic [7:0] addr, // register address
  input wire logic [15:0] wdata, // write data
  input wire logic wr, // write strobe
  input wire logic rd, // read strobe
  output logic [15:0] rdata, // read data, cycle after rd
  input wire logic channel_switch, // sequencer moved to a new channel
  input wire logic single_channel, // only one channel enabled
  input wire logic result_written, // filter wrote a conversion result
  input wire logic result_settled, // that result is fully settled
  input wire logic cal_written, // calibration result written
  input wire logic rate_absorbs, // selected rate can hide the delay
  input wire logic data_read, // data register was read
  output logic ready_n, // low while a new result waits
  output logic filter_reset, // one-cycle filter restart
  output logic conv_start, // one-cycle conversion start
  output logic cal_start, // one-cycle calibration start
  output logic [2:0] op_mode, // active operating mode
  output logic process_enable, // modulator may process input
  output logic standby, // standby mode, or sequencer idle outside power-down
  output logic power_down, // power-down mode
  output logic reference_enable, // internal reference and buffer on
  output clock_ctl_t clock_ctl, // master clock source controls
  output logic irq // level interrupt
);

  localparam logic [16:0] DLY_4US_CYC = 17'(`NS_TO_CYC(`DLY_4US_NS));
  localparam logic [16:0] DLY_16US_CYC = 17'(`NS_TO_CYC(`DLY_16US_NS));
  localparam logic [16:0] DLY_40US_CYC = 17'(`NS_TO_CYC(`DLY_40US_NS));

  // delay code to cycle count; code 0 means no wait
  function automatic logic [16:0] delay_cycles(input logic [2:0] sel);
    logic [16:0] c;
    case (sel)
      3'h1: c = DLY_4US_CYC;
      3'h2: c = DLY_16US_CYC;
      3'h3: c = DLY_40US_CYC;
      3'h4: c = 17'(DELAY_100US_CYC);
      3'h5: c = 17'(DELAY_200US_CYC);
      3'h6: c = 17'(DELAY_500US_CYC);
      3'h7: c = 17'(DELAY_1MS_CYC);
      default: c = 17'h00000;
    endcase
    return c;
  endfunction

  // register file
  mode_ctl_t ctrl_q, ctrl_d;
  logic [15:0] if_mode_q, if_mode_d;
  logic [`IRQ_BITS-1:0] irq_stat_q, irq_stat_d;
  logic [`IRQ_BITS-1:0] irq_mask_q, irq_mask_d;
  logic [15:0] rdata_q, rdata_d;
  logic mode_wr;
  logic absorb;

  // sequencer
  seq_state_t state_q, state_d;
  logic [16:0] dly_cnt_q, dly_cnt_d;
  logic ready_n_q, ready_n_d;
  logic filter_reset_q, filter_reset_d;
  logic conv_start_q, conv_start_d;
  logic cal_start_q, cal_start_d;
  logic process_q, process_d;
  logic [`IRQ_BITS-1:0] event_set;
  logic accept;

  // registered outputs
  clock_ctl_t clk_q, clk_d;
  logic ref_q, ref_d;
  logic standby_q, standby_d;
  logic pd_q, pd_d;
  logic irq_q, irq_d;

  assign mode_wr = wr && (addr == `ADDR_MODE_CTL);
  assign absorb = if_mode_q[`IF_DELAY_ABSORB_BIT] && rate_absorbs;

  always_comb begin
    ctrl_d = ctrl_q;
    if_mode_d = if_mode_q;
    irq_mask_d = irq_mask_q;
    rdata_d = 16'h0000;
    if (mode_wr) begin
      ctrl_d = mode_ctl_t'(wdata & `MODE_CTL_WMASK);
    end
    if (wr && addr == `ADDR_IF_MODE) begin
      if_mode_d = wdata & `IF_MODE_WMASK;
    end
    if (wr && addr == `ADDR_IRQ_MASK) begin
      irq_mask_d = wdata[`IRQ_BITS-1:0];
    end
    if (rd) begin
      case (addr)
        `ADDR_MODE_CTL: rdata_d = ctrl_q;
        `ADDR_IF_MODE: rdata_d = if_mode_q;
        `ADDR_IRQ_STATUS: rdata_d = {13'h0000, irq_stat_q};
        `ADDR_IRQ_MASK: rdata_d = {13'h0000, irq_mask_q};
        `ADDR_STATE: rdata_d = {11'h000, process_q, ready_n_q, 3'(state_q)};
        default: rdata_d = 16'h0000;
      endcase
    end
  end

  // status bits: event set wins over a write-one clear
  always_comb begin
    irq_stat_d = irq_stat_q;
    if (wr && addr == `ADDR_IRQ_STATUS) begin
      irq_stat_d = irq_stat_q & ~wdata[`IRQ_BITS-1:0];
    end
    irq_stat_d = irq_stat_d | event_set;
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_q <= mode_ctl_t'(`MODE_CTL_RESET);
      if_mode_q <= `IF_MODE_RESET;
      irq_stat_q <= '0;
      irq_mask_q <= '0;
      rdata_q <= 16'h0000;
    end else begin
      ctrl_q <= ctrl_d;
      if_mode_q <= if_mode_d;
      irq_stat_q <= irq_stat_d;
      irq_mask_q <= irq_mask_d;
      rdata_q <= rdata_d;
    end
  end

  // unsettled results dropped in single channel settled mode
  assign accept = result_written && (!(ctrl_q.settled_rate_only && single_channel) || result_settled);

  always_comb begin
    state_d = state_q;
    dly_cnt_d = dly_cnt_q;
    ready_n_d = ready_n_q;
    filter_reset_d = 1'b0;
    conv_start_d = 1'b0;
    cal_start_d = 1'b0;
    process_d = process_q;
    event_set = '0;
    if (data_read) begin
      ready_n_d = 1'b1;
    end
    case (state_q)
      st_convert: begin
        if (channel_switch && !absorb && ctrl_q.delay_sel != 3'h0) begin
          state_d = st_delay;
          dly_cnt_d = delay_cycles(ctrl_q.delay_sel);
          process_d = 1'b0;
        end else if (accept) begin
          ready_n_d = 1'b0;
          event_set[`IRQ_RESULT] = 1'b1;
          if (ctrl_q.op_mode == `OP_SINGLE) begin
            state_d = st_idle;
            process_d = 1'b0;
          end
        end
      end
      st_delay: begin
        if (dly_cnt_q <= 17'h00001) begin
          state_d = st_convert;
          dly_cnt_d = 17'h00000;
          process_d = 1'b1;
          event_set[`IRQ_DELAY_DONE] = 1'b1;
        end else begin
          dly_cnt_d = dly_cnt_q - 17'h00001;
        end
      end
      st_calib: begin
        if (cal_written) begin
          ready_n_d = 1'b0;
          event_set[`IRQ_CAL_DONE] = 1'b1;
          state_d = st_idle;
          process_d = 1'b0;
        end
      end
      st_idle: begin
        state_d = st_idle;
      end
      default: begin
        state_d = st_idle;
        process_d = 1'b0;
      end
    endcase
    // a mode write restarts filter and ready
    if (mode_wr) begin
      filter_reset_d = 1'b1;
      ready_n_d = 1'b1;
      dly_cnt_d = 17'h00000;
      event_set = '0;
      // next activity from the new mode
      case (wdata[6:4])
        `OP_CONTINUOUS, `OP_SINGLE: begin
          state_d = st_convert;
          conv_start_d = 1'b1;
          process_d = 1'b1;
        end
        `OP_INT_OFFSET_CAL, `OP_SYS_OFFSET_CAL, `OP_SYS_GAIN_CAL: begin
          state_d = st_calib;
          cal_start_d = 1'b1;
          process_d = 1'b1;
        end
        default: begin
          state_d = st_idle;
          process_d = 1'b0;
        end
      endcase
    end
  end

  // out of reset the part converts continuously
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= st_convert;
      dly_cnt_q <= 17'h00000;
      ready_n_q <= 1'b1;
      filter_reset_q <= 1'b0;
      conv_start_q <= 1'b0;
      cal_start_q <= 1'b0;
      process_q <= 1'b1;
    end else begin
      state_q <= state_d;
      dly_cnt_q <= dly_cnt_d;
      ready_n_q <= ready_n_d;
      filter_reset_q <= filter_reset_d;
      conv_start_q <= conv_start_d;
      cal_start_q <= cal_start_d;
      process_q <= process_d;
    end
  end

  // clock and reference controls lag the register by one cycle
  always_comb begin
    clk_d = '0;
    case (ctrl_q.clock_source_select)
      // internal oscillator forced on when chosen
      `CLK_INT_OSC: clk_d.osc_on = 1'b1;
      `CLK_INT_OSC_OUT: begin
        clk_d.osc_on = 1'b1;
        clk_d.osc_to_crystal_pin_two = 1'b1;
      end
      `CLK_EXT_CLOCK: clk_d.ext_clock_in = 1'b1;
      default: clk_d.crystal_on = 1'b1;
    endcase
    ref_d = ctrl_q.ref_en;
    standby_d = (ctrl_q.op_mode == `OP_STANDBY) || (state_q == st_idle && ctrl_q.op_mode != `OP_POWER_DOWN);
    pd_d = ctrl_q.op_mode == `OP_POWER_DOWN;
    irq_d = |(irq_stat_q & irq_mask_q);
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      clk_q <= '{osc_on: 1'b1, default: 1'b0};
      ref_q <= 1'b1;
      standby_q <= 1'b0;
      pd_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      clk_q <= clk_d;
      ref_q <= ref_d;
      standby_q <= standby_d;
      pd_q <= pd_d;
      irq_q <= irq_d;
    end
  end

  assign rdata = rdata_q;
  assign ready_n = ready_n_q;
  assign filter_reset = filter_reset_q;
  assign conv_start = conv_start_q;
  assign cal_start = cal_start_q;
  assign op_mode = ctrl_q.op_mode;
  assign process_enable = process_q;
  assign standby = standby_q;
  assign power_down = pd_q;
  assign reference_enable = ref_q;
  assign clock_ctl = clk_q;
  assign irq = irq_q;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);

  sequence s_mode_write(logic [2:0] m);
    wr && addr == `ADDR_MODE_CTL && wdata[6:4] == m;
  endsequence

  sequence s_switch_wait;
    state_q == st_convert && channel_switch && !absorb && ctrl_q.delay_sel == 3'h1 && !mode_wr;
  endsequence

  a_write_restarts: assert property (mode_wr |=> filter_reset_q && ready_n_q)
    else $error("mode write did not restart filter and ready");
  // back-to-back continuous writes may keep the start pulse up
  a_write_starts_conv: assert property (s_mode_write(`OP_CONTINUOUS) |=>
    conv_start_q && !cal_start_q ##1 (!conv_start_q || $past(mode_wr)))
    else $error("continuous write did not pulse conversion start");
  a_mode_readback: assert property (rd && addr == `ADDR_MODE_CTL |=> rdata_q == $past(ctrl_q))
    else $error("mode register read back wrong");
  a_reference_follows: assert property (mode_wr && !wdata[15] |=> ##1 !reference_enable)
    else $error("reference stayed on after clear");
  a_reserved_zero: assert property ((ctrl_q & ~`MODE_CTL_WMASK) == 16'h0000)
    else $error("reserved mode bits nonzero");
  a_settled_only: assert property (state_q == st_convert && ctrl_q.settled_rate_only && single_channel &&
    result_written && !result_settled && ready_n_q && !channel_switch && !mode_wr |=> ready_n_q)
    else $error("unsettled result flagged ready");
  a_delay_stall: assert property (s_switch_wait |=> !process_enable [*8] ##[1:400] process_enable)
    else $error("channel switch delay wrong");
  a_standby_idle: assert property (s_mode_write(`OP_STANDBY) |=>
    !conv_start_q && !cal_start_q && state_q == st_idle)
    else $error("standby write started activity");
  a_osc_enabled: assert property (mode_wr && wdata[3:2] == `CLK_INT_OSC |=>
    ##1 clock_ctl.osc_on && !clock_ctl.crystal_on)
    else $error("internal oscillator not enabled");
  a_crystal_select: assert property (mode_wr && wdata[3:2] == `CLK_EXT_CRYSTAL |=>
    ##1 clock_ctl.crystal_on && !clock_ctl.osc_on)
    else $error("crystal source not selected");
  a_cal_ready: assert property (state_q == st_calib && cal_written && !mode_wr |=>
    !ready_n_q && state_q == st_idle)
    else $error("calibration result did not raise ready");
  // a result in the switch cycle may legally end a single conversion
  a_absorb_no_stall: assert property (state_q == st_convert && channel_switch && absorb &&
    !result_written && !mode_wr |=> process_enable)
    else $error("absorbed delay stalled processing");
  a_undefined_mode: assert property (s_mode_write(`OP_UNDEFINED) |=>
    !conv_start_q && !cal_start_q && !process_enable)
    else $error("undefined mode started activity");

endmodule

// ---- test/filter_model.sv ----
// far-side model: filter and channel sequencer events toward the mode control block
`timescale 1ns/100ps

module filter_model #(
  parameter int CAL_CYC = 10
) (
  clock, // 100 MHz
  reset_n, // async, active low
  req_result, // bench asks for one result
  req_switch, // bench asks for a channel switch
  cal_start, // calibration begins
  result_written, // result pulse
  channel_switch, // channel switch pulse
  cal_written // calibration result pulse
);
  input wire logic clock;
  input wire logic reset_n;
  input wire logic req_result;
  input wire logic req_switch;
  input wire logic cal_start;
  output logic result_written;
  output logic channel_switch;
  output logic cal_written;
  logic [7:0] cal_cnt_q;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      result_written <= 1'b0;
      channel_switch <= 1'b0;
      cal_written <= 1'b0;
      cal_cnt_q <= 8'h00;
    end else begin
      result_written <= req_result;
      channel_switch <= req_switch;
      cal_written <= (cal_cnt_q == 8'h01);
      // a new start restarts the timer, as a real filter would
      if (cal_start) begin
        cal_cnt_q <= CAL_CYC[7:0];
      end else if (cal_cnt_q != 8'h00) begin
        cal_cnt_q <= cal_cnt_q - 8'h01;
      end
    end
  end
endmodule

// ---- test/tb.sv ----
// self-checking bench for the mode control block
`timescale 1ns/100ps
`include "adc_mode_control_params.svh"

module tb;
  import adc_mode_control_pkg::*;
  logic clock, reset_n, wr, rd, single_channel, result_settled, rate_absorbs, data_read;
  logic req_result, req_switch, result_written, channel_switch, cal_written;
  logic ready_n, filter_reset, conv_start, cal_start, process_enable, standby, power_down;
  logic reference_enable, irq;
  logic [7:0] addr;
  logic [15:0] wdata, rdata, rv;
  logic [2:0] op_mode;
  clock_ctl_t clock_ctl;
  int fail_count, compares, n;
  int dly_exp [8] = '{0, 400, 1600, 4000, 20, 30, 40, 50};

  // short delay counts keep the run brief
  adc_mode_control #(.DELAY_100US_CYC(20), .DELAY_200US_CYC(30), .DELAY_500US_CYC(40),
    .DELAY_1MS_CYC(50)) i_dut (.clock(clock), .reset_n(reset_n), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .channel_switch(channel_switch),
    .single_channel(single_channel), .result_written(result_written),
    .result_settled(result_settled), .cal_written(cal_written), .rate_absorbs(rate_absorbs),
    .data_read(data_read), .ready_n(ready_n), .filter_reset(filter_reset),
    .conv_start(conv_start), .cal_start(cal_start), .op_mode(op_mode),
    .process_enable(process_enable), .standby(standby), .power_down(power_down),
    .reference_enable(reference_enable), .clock_ctl(clock_ctl), .irq(irq));

  filter_model i_far (.clock(clock), .reset_n(reset_n), .req_result(req_result),
    .req_switch(req_switch), .cal_start(cal_start), .result_written(result_written),
    .channel_switch(channel_switch), .cal_written(cal_written));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic wrap_up();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wreg(input logic [7:0] a, input logic [15:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
    #1;
  endtask

  task automatic wmode(input logic [15:0] d);
    wreg(`ADDR_MODE_CTL, d);
  endtask

  task automatic rreg(input logic [7:0] a);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1;
    rv = rdata;
  endtask

  task automatic step();
    @(posedge clock);
    #1;
  endtask

  task automatic emit(input logic settled);
    @(posedge clock);
    req_result <= 1'b1;
    result_settled <= settled;
    @(posedge clock);
    req_result <= 1'b0;
    repeat (3) @(posedge clock);
    #1;
  endtask

  // cycles that input processing is held off after one channel switch
  task automatic delay_len(output int len);
    int k;
    len = 0;
    k = 0;
    @(posedge clock);
    req_switch <= 1'b1;
    @(posedge clock);
    req_switch <= 1'b0;
    while (process_enable !== 1'b0 && k < 4) begin
      step();
      k++;
    end
    while (process_enable === 1'b0) begin
      step();
      len++;
      if (len > 150000) begin
        fail_count++;
        wrap_up();
      end
    end
  endtask

  initial begin
    {wr, rd, single_channel, result_settled, rate_absorbs, data_read, req_result, req_switch} = 8'h00;
    addr = 8'h00;
    wdata = 16'h0000;
    reset_n = 1'b0;
    repeat (12) @(posedge clock);
    reset_n <= 1'b1;
    #1;
    // ready_n, reference_enable, clock_ctl, op_mode, irq
    chk({6'h00, ready_n, reference_enable, clock_ctl, op_mode, irq}, 16'h0380);
    rreg(`ADDR_MODE_CTL);
    chk(rv, 16'h8000);
    wmode(16'hffff);
    rreg(`ADDR_MODE_CTL);
    chk(rv, 16'ha77c);
    rreg(8'h55);
    chk(rv, 16'h0000);
    for (int m = 0; m < 8; m++) begin
      wmode(16'h8000 | (16'(m) << 4));
      chk({13'h0, filter_reset, conv_start, cal_start}, {13'h0, 1'b1, m < 2, m >= 4 && m != 5});
      step();
      chk({11'h0, op_mode, standby, power_down}, {11'h0, 3'(m), m == 2 || m == 5, m == 3});
    end
    for (int c = 0; c < 4; c++) begin
      wmode(16'h8020 | (16'(c) << 2));
      step();
      chk({12'h0, clock_ctl}, {12'h0, c < 2, c == 1, c == 2, c == 3});
    end
    wmode(16'h0000);
    step();
    chk({15'h0, reference_enable}, 16'h0000);
    wmode(16'h8070);
    n = 0;
    while (ready_n !== 1'b0 && n < 40) begin
      step();
      n++;
    end
    chk({15'h0, ready_n}, 16'h0000);
    repeat (2) step();
    chk({15'h0, standby}, 16'h0001);
    wmode(16'h8000);
    chk({15'h0, ready_n}, 16'h0001);
    for (int k = 0; k < 8; k++) begin
      wmode(16'h8000 | (16'(k) << 8));
      delay_len(n);
      chk(16'(n), 16'(dly_exp[k]));
    end
    wreg(`ADDR_IF_MODE, 16'h0400);
    @(posedge clock);
    rate_absorbs <= 1'b1;
    wmode(16'h8400);
    delay_len(n);
    chk(16'(n), 16'h0000);
    @(posedge clock);
    rate_absorbs <= 1'b0;
    wreg(`ADDR_IF_MODE, 16'h0000);
    wreg(`ADDR_IRQ_STATUS, 16'h0007);
    wreg(`ADDR_IRQ_MASK, 16'h0001);
    wmode(16'ha000);
    @(posedge clock);
    single_channel <= 1'b1;
    emit(1'b0);
    chk({15'h0, ready_n}, 16'h0001);
    emit(1'b1);
    chk({14'h0, ready_n, irq}, 16'h0001);
    rreg(`ADDR_IRQ_STATUS);
    chk(rv, 16'h0001);
    wreg(`ADDR_IRQ_STATUS, 16'h0001);
    step();
    chk({15'h0, irq}, 16'h0000);
    @(posedge clock);
    data_read <= 1'b1;
    @(posedge clock);
    data_read <= 1'b0;
    #1;
    chk({15'h0, ready_n}, 16'h0001);
    @(posedge clock);
    single_channel <= 1'b0;
    emit(1'b0);
    chk({15'h0, ready_n}, 16'h0000);
    wreg(`ADDR_IRQ_MASK, 16'h0000);
    step();
    chk({15'h0, irq}, 16'h0000);
    rreg(`ADDR_IRQ_STATUS);
    chk(rv, 16'h0001);
    wmode(16'h8000);
    chk({14'h0, ready_n, filter_reset}, 16'h0003);
    wrap_up();
  end
endmodule
